// ### bench/bus_control_config_fields_asserts.sv
// checker: timing relations at the ports of the configuration block
// assumes: bound to the top module, every input synchronous to hclk
`timescale 1ns/100ps
module bus_control_config_fields_asserts
    import bus_ctrl_pkg::*;
(
    // clock, reset and register bus
    input wire logic        hclk, hresetn, hsel, hwrite, hready,
    input wire logic [31:0] haddr, hwdata, hrdata,
    input wire logic [1:0]  htrans,
    input wire logic [2:0]  hsize,
    // pins and fields
    input wire logic        ext_bus_released, ext_access_pending, breq_pin_oe,
    input wire logic        gpio_breq_oe, wait_pin_in, wait_pin_oe, gpio_wait_oe,
    input wire logic        cycle_wait, ack_request, transfer_ack, bus_request_out,
    input wire logic        bus_release_enable, bus_request_out_enable,
    input wire logic        write_buffer_enable, wait_pin_enable, ack_edge_select
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_ctl_addr;
        hsel && hready && htrans[1] && hwrite && hsize == HSIZE_WORD && haddr == ADDR_CONTROL;
    endsequence
    sequence s_ctl_write;
        s_ctl_addr ##1 hready;
    endsequence

    a_req_drive: assert property (hresetn |=> bus_request_out ==
        $past(bus_release_enable && bus_request_out_enable && ext_bus_released
        && ext_access_pending)) else $error("request output wrong");
    a_req_oe_on: assert property ($past(hresetn) && $past(bus_request_out_enable)
        |-> breq_pin_oe) else $error("request pin not driven");
    a_req_port: assert property ($past(hresetn) && !$past(bus_request_out_enable)
        |-> breq_pin_oe == $past(gpio_breq_oe)) else $error("request pin not released");
    a_resv_ro: assert property (hrdata[13:12] == 2'h0)
        else $error("bits 13:12 not zero");
    a_resv_rw: assert property (hrdata[11:10] == 2'h0)
        else $error("bits 11:10 not zero");
    a_bit6_zero: assert property (!hrdata[6])
        else $error("bit 6 not zero");
    a_wait_gate: assert property (cycle_wait == (wait_pin_enable && wait_pin_in))
        else $error("wait gating wrong");
    a_wait_port: assert property ($past(hresetn) && !$past(wait_pin_enable)
        |-> wait_pin_oe == $past(gpio_wait_oe)) else $error("wait pin not released");
    a_ack_rise: assert property ($past(hresetn) && ack_edge_select
        |-> transfer_ack == $past(ack_request)) else $error("rising ack wrong");
    a_ack_fall: assert property (@(negedge hclk) disable iff (!hresetn)
        $past(hresetn) && !ack_edge_select |-> transfer_ack == $past(ack_request))
        else $error("falling ack wrong");
    a_field_upd: assert property (s_ctl_write |=> write_buffer_enable == $past(hwdata[9])
        && wait_pin_enable == $past(hwdata[8]) && ack_edge_select == $past(hwdata[7]))
        else $error("fields not updated");
endmodule : bus_control_config_fields_asserts

// ### bench/bus_control_config_fields_bench.sv
// testbench: drives register bus, pins and write source, judges the answers
// assumes: ext_cycle_model ends write cycles, one 200 MHz clock
`timescale 1ns/100ps
module bus_control_config_fields_bench;
    import bus_ctrl_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, ext_bus_released, ext_access_pending;
    logic        gpio_breq_out, gpio_breq_oe, wait_pin_in, gpio_wait_out, gpio_wait_oe;
    logic        wr_valid, ack_request, hreadyout, hresp, breq_pin_out, breq_pin_oe;
    logic        wait_pin_out, wait_pin_oe, gpio_wait_in, cycle_wait, wr_ready, wr_done;
    logic        cyc_valid, cyc_done, transfer_ack, bus_release_enable, bus_request_out;
    logic        bus_request_out_enable, write_buffer_enable, wait_pin_enable, ack_edge_select;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [23:0] wr_addr, cyc_addr;
    logic [15:0] wr_data, cyc_data;
    logic [3:0]  lat;
    int          n_mismatch, compares;

    bus_control_config_fields bus_control_config_fields_inst (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .ext_bus_released(ext_bus_released),
        .ext_access_pending(ext_access_pending), .breq_pin_out(breq_pin_out),
        .breq_pin_oe(breq_pin_oe), .gpio_breq_out(gpio_breq_out), .gpio_breq_oe(gpio_breq_oe),
        .wait_pin_in(wait_pin_in), .wait_pin_out(wait_pin_out), .wait_pin_oe(wait_pin_oe),
        .gpio_wait_out(gpio_wait_out), .gpio_wait_oe(gpio_wait_oe),
        .gpio_wait_in(gpio_wait_in), .cycle_wait(cycle_wait), .wr_valid(wr_valid),
        .wr_addr(wr_addr), .wr_data(wr_data), .wr_ready(wr_ready), .wr_done(wr_done),
        .cyc_valid(cyc_valid), .cyc_addr(cyc_addr), .cyc_data(cyc_data),
        .cyc_done(cyc_done), .ack_request(ack_request), .transfer_ack(transfer_ack),
        .bus_release_enable(bus_release_enable), .bus_request_out_enable(bus_request_out_enable),
        .write_buffer_enable(write_buffer_enable), .wait_pin_enable(wait_pin_enable),
        .ack_edge_select(ack_edge_select), .bus_request_out(bus_request_out));

    ext_cycle_model ext_cycle_model_inst (.hclk(hclk), .hresetn(hresetn),
        .cyc_valid(cyc_valid), .lat(lat), .cyc_done(cyc_done));

    always #2.5 hclk = ~hclk;

    task automatic conclude();
        if (n_mismatch == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // bounded so a stuck slave ends the run instead of hanging it
    task automatic wait_ready();
        int i;
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (hreadyout !== 1'b1 && i < 64);
        if (hreadyout !== 1'b1) begin
            n_mismatch++;
            conclude();
        end
    endtask : wait_ready

    // a wait that used up its bound ends the run as a failure
    task automatic bound(input int i);
        if (i >= 64) begin
            n_mismatch++;
            conclude();
        end
    endtask : bound

    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= a;
        hsize  <= HSIZE_WORD;
        wait_ready();
        htrans <= HTRANS_IDLE;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask : ahb

    task automatic t_regs();
        ahb(0, ADDR_CONTROL, 0);
        chk(rd, 0);
        // software keeps bits 11, 10 and 6 at 0 on every write
        ahb(1, ADDR_CONTROL, 32'hFFFF_F3BF);
        @(posedge hclk);
        chk({29'h0, write_buffer_enable, wait_pin_enable, ack_edge_select}, 32'h7);
        for (int b = 6; b < 16; b++) begin
            ahb(1, ADDR_CONTROL, (32'h1 << b) & ~32'h0000_0C40);
            ahb(0, ADDR_CONTROL, 0);
            chk(rd, (32'h1 << b) & 32'h0000_C380);
        end
        ahb(1, 32'h0000_0010, 32'hFFFF_FFFF);
        ahb(0, 32'h0000_0010, 0);
        chk(rd, 0);
        ahb(0, ADDR_CONTROL, 0);
        chk(rd, 32'h0000_8000);
    endtask : t_regs

    task automatic t_request();
        ahb(1, ADDR_CONTROL, 32'h0000_C000);
        ext_bus_released   <= 1'b1;
        ext_access_pending <= 1'b1;
        repeat (3) @(posedge hclk);
        chk(bus_request_out, 1);
        chk({breq_pin_oe, breq_pin_out}, 2'h3);
        ahb(0, ADDR_STATUS, 0);
        chk(hresp, HRESP_OKAY);
        chk(rd, 32'h1 << STAT_REQ_OUT);
        ahb(1, ADDR_CONTROL, 32'h0000_8000);
        repeat (3) @(posedge hclk);
        chk(bus_request_out, 0);
        chk(breq_pin_oe, 0);
        gpio_breq_oe  <= 1'b1;
        gpio_breq_out <= 1'b1;
        repeat (3) @(posedge hclk);
        chk({breq_pin_oe, breq_pin_out}, 2'h3);
        ext_access_pending <= 1'b0;
        ext_bus_released   <= 1'b0;
    endtask : t_request

    task automatic t_wait();
        wait_pin_in   <= 1'b1;
        gpio_wait_oe  <= 1'b1;
        gpio_wait_out <= 1'b1;
        repeat (3) @(posedge hclk);
        chk(cycle_wait, 0);
        chk({wait_pin_oe, wait_pin_out, gpio_wait_in}, 3'h7);
        ahb(1, ADDR_CONTROL, 32'h0000_0100);
        repeat (2) @(posedge hclk);
        chk(cycle_wait, 1);
        chk({wait_pin_oe, wait_pin_out}, 2'h0);
        wait_pin_in <= 1'b0;
    endtask : t_wait

    // a half-cycle look tells the falling launch from the rising one
    task automatic t_ack(input logic sel);
        ahb(1, ADDR_CONTROL, {24'h0, sel, 7'h0});
        ack_request <= 1'b1;
        #3;
        chk(transfer_ack, !sel);
        @(posedge hclk);
        #1;
        chk(transfer_ack, 1);
        @(posedge hclk);
        ack_request <= 1'b0;
        #3;
        chk(transfer_ack, sel);
        @(posedge hclk);
    endtask : t_ack

    task automatic t_wbuf(input logic post, input logic [3:0] l, input logic [15:0] d);
        int i;
        lat <= l;
        ahb(1, ADDR_CONTROL, {22'h0, post, 9'h0});
        // the new mode may miss the very next access, so let the buffer idle first
        repeat (2) @(posedge hclk);
        wr_valid <= 1'b1;
        wr_data  <= d;
        wr_addr  <= {8'h0, d};
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (wr_ready !== 1'b1 && i < 64);
        bound(i);
        wr_valid <= 1'b0;
        i = 0;
        do begin
            @(posedge hclk);
            i++;
            if (cyc_valid === 1'b1) begin
                chk({wr_ready, cyc_data, cyc_addr[15:0]}, {1'b0, d, d});
            end
        end while (wr_done !== 1'b1 && i < 64);
        bound(i);
        chk({wr_done, cyc_valid}, {1'b1, post});
        i = 0;
        while (cyc_valid !== 1'b0 && i < 64) begin
            @(posedge hclk);
            i++;
        end
        bound(i);
        chk(wr_ready, 1);
    endtask : t_wbuf

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        {hsel, hwrite, ext_bus_released, ext_access_pending, gpio_breq_out, gpio_breq_oe,
            wait_pin_in, gpio_wait_out, gpio_wait_oe, wr_valid, ack_request} = '0;
        {htrans, hsize, haddr, hwdata, wr_addr, wr_data, lat} = '0;
        n_mismatch = 0;
        compares = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_request();
        t_wait();
        t_ack(1'b1);
        t_ack(1'b0);
        t_wbuf(1'b0, 4'h0, 16'hA5C3);
        t_wbuf(1'b1, 4'h5, 16'h5A3C);
        conclude();
    end
endmodule : bus_control_config_fields_bench

bind bus_control_config_fields bus_control_config_fields_asserts
    bus_control_config_fields_asserts_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .hwrite(hwrite), .hready(hready), .haddr(haddr), .hwdata(hwdata), .hrdata(hrdata),
    .htrans(htrans), .hsize(hsize), .ext_bus_released(ext_bus_released),
    .ext_access_pending(ext_access_pending), .breq_pin_oe(breq_pin_oe),
    .gpio_breq_oe(gpio_breq_oe), .wait_pin_in(wait_pin_in), .wait_pin_oe(wait_pin_oe),
    .gpio_wait_oe(gpio_wait_oe), .cycle_wait(cycle_wait), .ack_request(ack_request),
    .transfer_ack(transfer_ack), .bus_request_out(bus_request_out),
    .bus_release_enable(bus_release_enable), .bus_request_out_enable(bus_request_out_enable),
    .write_buffer_enable(write_buffer_enable), .wait_pin_enable(wait_pin_enable),
    .ack_edge_select(ack_edge_select));

// ### bench/ext_cycle_model.sv
// model: far-side bus-cycle engine ending each write cycle the block offers
// assumes: cyc_valid holds until cyc_done; lat sets the engine's idle cycles
`timescale 1ns/100ps
module ext_cycle_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       cyc_valid,
    input  wire logic [3:0] lat,
    output logic            cyc_done
);
    logic [3:0] cnt;

    // single-cycle done; not repeated while the block drops cyc_valid
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt      <= 4'h0;
            cyc_done <= 1'b0;
        end else if (cyc_valid && !cyc_done && cnt != lat) begin
            cnt <= cnt + 4'h1;
        end else begin
            cyc_done <= cyc_valid && !cyc_done;
            cnt      <= 4'h0;
        end
    end
endmodule : ext_cycle_model

// ### hdl/bus_cfg_if.sv
// interface: configuration fields passed from the register file to the leaf modules
// assumes: one driver (ctrl) and any number of readers (user)
`timescale 1ns/100ps
interface bus_cfg_if;
    logic write_buffer_enable;
    logic ack_edge_select;

    modport ctrl (output write_buffer_enable, output ack_edge_select);
    modport user (input  write_buffer_enable, input  ack_edge_select);
endinterface : bus_cfg_if

// ### hdl/bus_control_config_fields.sv
// bus_control_config_fields: AHB-Lite register bank steering the external bus pins
// assumes: single AHB-Lite slave, word transfers, pin inputs synchronous to hclk
//
// Function
// - drive bus request out while bus released and internal access pending, if enabled
// - request enable 0 leaves the request pin to the general port, 1 enables it
// - bits 13 and 12 read 0 and ignore writes
// - bits 11 and 10 read 0; software writes 0 there
// - write buffer bit 9, wait pin bit 8, ack edge bit 7; reset 0, read/write
// - write buffer enable 1 posts external and single-address dma writes
// - a write buffer setting change may miss the very next external access
// - wait pin enable 0 ignores the wait input, 1 stretches cycles with it
// - with wait input disabled the wait pin belongs to the general port
// - ack edge select 0 asserts acknowledge on falling edge, 1 on rising edge
// - bit 6 reads 0 though writable; software writes 0 there; here writes to it are not stored
`timescale 1ns/100ps
module bus_control_config_fields (
    // clock and reset
    input  wire logic                               hclk,
    input  wire logic                               hresetn,
    // AHB-Lite slave
    input  wire logic                               hsel,
    input  wire logic [31:0]                        haddr,
    input  wire logic [1:0]                         htrans,
    input  wire logic                               hwrite,
    input  wire logic [2:0]                         hsize,
    input  wire logic [31:0]                        hwdata,
    input  wire logic                               hready,
    output logic [31:0]                             hrdata,
    output logic                                    hreadyout,
    output logic                                    hresp,
    // bus release status from the bus arbiter
    input  wire logic                               ext_bus_released,
    input  wire logic                               ext_access_pending,
    // bus request pin and its general port
    output logic                                    breq_pin_out,
    output logic                                    breq_pin_oe,
    input  wire logic                               gpio_breq_out,
    input  wire logic                               gpio_breq_oe,
    // wait pin and its general port
    input  wire logic                               wait_pin_in,
    output logic                                    wait_pin_out,
    output logic                                    wait_pin_oe,
    input  wire logic                               gpio_wait_out,
    input  wire logic                               gpio_wait_oe,
    output logic                                    gpio_wait_in,
    // wait toward the bus-cycle engine
    output logic                                    cycle_wait,
    // write source
    input  wire logic                               wr_valid,
    input  wire logic [bus_ctrl_pkg::EXT_ADDR_W-1:0] wr_addr,
    input  wire logic [bus_ctrl_pkg::EXT_DATA_W-1:0] wr_data,
    output logic                                    wr_ready,
    output logic                                    wr_done,
    // write cycle toward the bus-cycle engine
    output logic                                    cyc_valid,
    output logic [bus_ctrl_pkg::EXT_ADDR_W-1:0]     cyc_addr,
    output logic [bus_ctrl_pkg::EXT_DATA_W-1:0]     cyc_data,
    input  wire logic                               cyc_done,
    // dma transfer acknowledge
    input  wire logic                               ack_request,
    output logic                                    transfer_ack,
    // configuration levels for the rest of the bus controller
    output logic                                    bus_release_enable,
    output logic                                    bus_request_out_enable,
    output logic                                    write_buffer_enable,
    output logic                                    wait_pin_enable,
    output logic                                    ack_edge_select,
    output logic                                    bus_request_out
);
    import bus_ctrl_pkg::*;

    // address phase captured for the data phase
    acc_sel_t    sel_q;
    logic        write_q;
    logic        access;
    acc_sel_t    sel_now;

    // storage
    logic [15:0] control;
    logic [15:0] next_control;
    logic [15:0] status;
    logic        buf_active;

    bus_cfg_if   cfg ();

    // ---- bus side ----

    // only whole-word transfers reach the registers; others complete with no effect
    assign access  = hsel && hready && (htrans != HTRANS_IDLE) && (hsize == HSIZE_WORD);
    assign sel_now = access ? decode_addr(haddr) : ACC_NONE;

    // zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = HRESP_OKAY;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_q   <= ACC_NONE;
            write_q <= 1'b0;
        end else if (hready) begin
            sel_q   <= sel_now;
            write_q <= access && hwrite;
        end
    end

    // reserved bits are masked out here, so they never store and always read 0
    always_comb begin
        next_control = control;
        if (write_q && (sel_q == ACC_CONTROL) && hready) begin
            next_control = hwdata[15:0] & CONTROL_STORE_MASK;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            control <= CONTROL_RESET;
        end else begin
            control <= next_control;
        end
    end

    // read data is fetched in the address phase; next_control forwards a write
    // still in its data phase so a read right behind it sees the new value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready) begin
            if (sel_now == ACC_CONTROL && !hwrite) begin
                hrdata <= {16'h0000, next_control & CONTROL_STORE_MASK};
            end else if (sel_now == ACC_STATUS && !hwrite) begin
                hrdata <= {16'h0000, status};
            end else begin
                hrdata <= 32'h0000_0000;
            end
        end
    end

    // ---- field outputs ----

    assign bus_release_enable     = control[BIT_RELEASE_ENABLE];
    assign bus_request_out_enable = control[BIT_REQ_OUT_ENABLE];
    assign write_buffer_enable    = control[BIT_WRITE_BUFFER];
    assign wait_pin_enable        = control[BIT_WAIT_PIN];
    assign ack_edge_select        = control[BIT_ACK_EDGE];

    assign cfg.write_buffer_enable = write_buffer_enable;
    assign cfg.ack_edge_select     = ack_edge_select;

    // ---- bus request pin ----

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_request_out <= 1'b0;
        end else begin
            bus_request_out <= bus_release_enable && bus_request_out_enable
                               && ext_bus_released && ext_access_pending;
        end
    end

    // the pin follows the general port until the request output is enabled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            breq_pin_out <= 1'b0;
            breq_pin_oe  <= 1'b0;
        end else if (bus_request_out_enable) begin
            breq_pin_out <= bus_release_enable && ext_bus_released
                            && ext_access_pending;
            breq_pin_oe  <= 1'b1;
        end else begin
            breq_pin_out <= gpio_breq_out;
            breq_pin_oe  <= gpio_breq_oe;
        end
    end

    // ---- wait pin ----

    // combinational so a wait seen at an edge stretches that very cycle
    assign cycle_wait   = wait_pin_enable && wait_pin_in;

    // the port can always read the pin level
    assign gpio_wait_in = wait_pin_in;

    // while enabled the pin is an input, so the port may not drive it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_pin_out <= 1'b0;
            wait_pin_oe  <= 1'b0;
        end else if (wait_pin_enable) begin
            wait_pin_out <= 1'b0;
            wait_pin_oe  <= 1'b0;
        end else begin
            wait_pin_out <= gpio_wait_out;
            wait_pin_oe  <= gpio_wait_oe;
        end
    end

    // ---- status ----

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status <= 16'h0000;
        end else begin
            status                  <= 16'h0000;
            status[STAT_BUF_FULL]   <= cyc_valid;
            status[STAT_REQ_OUT]    <= bus_request_out;
            status[STAT_BUF_ACTIVE] <= buf_active;
            status[STAT_WAIT_SEEN]  <= cycle_wait;
            status[STAT_ACK_OUT]    <= transfer_ack;
        end
    end

    // ---- leaves ----

    write_data_buffer u_write_buffer (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .cfg        (cfg),
        .wr_valid   (wr_valid),
        .wr_addr    (wr_addr),
        .wr_data    (wr_data),
        .wr_ready   (wr_ready),
        .wr_done    (wr_done),
        .cyc_valid  (cyc_valid),
        .cyc_addr   (cyc_addr),
        .cyc_data   (cyc_data),
        .cyc_done   (cyc_done),
        .buf_active (buf_active)
    );

    transfer_ack_gen u_ack_gen (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .cfg          (cfg),
        .ack_request  (ack_request),
        .transfer_ack (transfer_ack)
    );

endmodule : bus_control_config_fields

// ### hdl/bus_ctrl_pkg.sv
// package: constants, field layout and types of the bus control configuration block
// assumes: shared by the top, its leaf modules, the checker and the testbench
package bus_ctrl_pkg;

    // register byte addresses on the AHB-Lite bus
    localparam logic [31:0] ADDR_CONTROL       = 32'h0000_0000;
    localparam logic [31:0] ADDR_STATUS        = 32'h0000_0004;

    // field positions of bus_control_one
    localparam int          BIT_RELEASE_ENABLE = 15;
    localparam int          BIT_REQ_OUT_ENABLE = 14;
    localparam int          BIT_WRITE_BUFFER   = 9;
    localparam int          BIT_WAIT_PIN       = 8;
    localparam int          BIT_ACK_EDGE       = 7;

    // reset value and the bits that really store
    localparam logic [15:0] CONTROL_RESET      = 16'h0000;
    localparam logic [15:0] CONTROL_STORE_MASK = 16'hC380;

    // field positions of the status register
    localparam int          STAT_BUF_FULL      = 0;
    localparam int          STAT_REQ_OUT       = 1;
    localparam int          STAT_BUF_ACTIVE    = 2;
    localparam int          STAT_WAIT_SEEN     = 3;
    localparam int          STAT_ACK_OUT       = 4;

    // AHB-Lite encodings
    localparam logic [1:0]  HTRANS_IDLE        = 2'h0;
    localparam logic [2:0]  HSIZE_WORD         = 3'h2;
    localparam logic        HRESP_OKAY         = 1'h0;

    // external bus widths
    localparam int          EXT_DATA_W         = 16;
    localparam int          EXT_ADDR_W         = 24;

    typedef enum logic {
        WB_EMPTY = 1'b0,
        WB_FULL  = 1'b1
    } wb_state_t;

    typedef enum logic [1:0] {
        ACC_NONE    = 2'b00,
        ACC_CONTROL = 2'b01,
        ACC_STATUS  = 2'b10
    } acc_sel_t;

    function automatic acc_sel_t decode_addr(input logic [31:0] addr);
        if (addr == ADDR_CONTROL) begin
            return ACC_CONTROL;
        end else if (addr == ADDR_STATUS) begin
            return ACC_STATUS;
        end else begin
            return ACC_NONE;
        end
    endfunction : decode_addr

endpackage : bus_ctrl_pkg

// ### hdl/transfer_ack_gen.sv
// transfer_ack_gen: launches the dma transfer acknowledge on the chosen clock edge
// assumes: ack_request comes from rising-edge logic of the same clock
`timescale 1ns/100ps
module transfer_ack_gen
    import bus_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // configuration
    bus_cfg_if.user   cfg,
    // acknowledge
    input  wire logic ack_request,
    output logic      transfer_ack
);
    logic ack_rise;
    logic ack_fall;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ack_rise <= 1'b0;
        end else begin
            ack_rise <= ack_request;
        end
    end

    // half a cycle sooner than the rising-edge flop
    always_ff @(negedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ack_fall <= 1'b0;
        end else begin
            ack_fall <= ack_request;
        end
    end

    assign transfer_ack = cfg.ack_edge_select ? ack_rise : ack_fall;
endmodule : transfer_ack_gen

// ### hdl/write_data_buffer.sv
// write_data_buffer: one-entry posting buffer for external and single-address dma writes
// assumes: the bus-cycle engine raises cyc_done for one cycle when a write cycle ends
`timescale 1ns/100ps
module write_data_buffer
    import bus_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    // configuration
    bus_cfg_if.user                    cfg,
    // write source
    input  wire logic                  wr_valid,
    input  wire logic [EXT_ADDR_W-1:0] wr_addr,
    input  wire logic [EXT_DATA_W-1:0] wr_data,
    output logic                       wr_ready,
    output logic                       wr_done,
    // toward the bus-cycle engine
    output logic                       cyc_valid,
    output logic [EXT_ADDR_W-1:0]      cyc_addr,
    output logic [EXT_DATA_W-1:0]      cyc_data,
    input  wire logic                  cyc_done,
    // state
    output logic                       buf_active
);
    wb_state_t state;
    logic      accept;

    assign accept    = wr_valid && (state == WB_EMPTY);
    assign wr_ready  = (state == WB_EMPTY);
    assign cyc_valid = (state == WB_FULL);

    // the setting is only taken between accesses, so an access already started keeps its mode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            buf_active <= 1'b0;
        end else if ((state == WB_EMPTY) && !wr_valid) begin
            buf_active <= cfg.write_buffer_enable;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state    <= WB_EMPTY;
            cyc_addr <= '0;
            cyc_data <= '0;
        end else if (accept) begin
            state    <= WB_FULL;
            cyc_addr <= wr_addr;
            cyc_data <= wr_data;
        end else if (cyc_done && (state == WB_FULL)) begin
            state    <= WB_EMPTY;
        end
    end

    // posted write finishes for the source at capture; otherwise at the end of the cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_done <= 1'b0;
        end else begin
            wr_done <= buf_active ? accept : (cyc_done && (state == WB_FULL));
        end
    end
endmodule : write_data_buffer
